// ### pkg/emc_pkg.sv
// emc_pkg: constants, states and carriers of the frame-level ethernet mac
// assumes a 4-bit media independent interface and a classic wishbone slave port
package emc_pkg;
  // register byte addresses
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_MAX_LEN = 8'h04;
  localparam logic [7:0] ADR_MAC_LO = 8'h08;
  localparam logic [7:0] ADR_MAC_HI = 8'h0C;
  localparam logic [7:0] ADR_TX_DATA = 8'h10;
  localparam logic [7:0] ADR_TX_CMD = 8'h14;
  localparam logic [7:0] ADR_RX_DATA = 8'h18;
  localparam logic [7:0] ADR_RX_STAT = 8'h1C;
  localparam logic [7:0] ADR_INT_STAT = 8'h20;
  localparam logic [7:0] ADR_INT_MASK = 8'h24;
  // control bits
  localparam int CTRL_FDX = 0;
  localparam int CTRL_PROM = 1;
  localparam int CTRL_MCAST = 2;
  localparam int CTRL_BCAST = 3;
  localparam int CTRL_KEEP_FCS = 4;
  localparam int TXC_GO = 0;
  localparam int TXC_CLR = 1;
  // interrupt status bits
  localparam int IRQ_TX_DONE = 0;
  localparam int IRQ_TX_ERR = 1;
  localparam int IRQ_RX_DONE = 2;
  localparam int IRQ_RX_ERR = 3;
  // frame layout
  localparam logic [15:0] MAX_LEN_RST = 16'h05EE;
  localparam logic [15:0] MIN_FRAME = 16'h0040;
  localparam logic [15:0] MIN_CRC = 16'h003C;
  localparam logic [15:0] ADDR_BYTES = 16'h0006;
  localparam logic [15:0] TX_HDR = 16'h0008;
  localparam logic [15:0] FCS_BYTES = 16'h0004;
  localparam logic [7:0] PRE_BYTE = 8'h55;
  localparam logic [7:0] SFD_BYTE = 8'h5D;
  localparam logic [7:0] PRE_NIBS = 8'h0E;
  localparam logic [3:0] JAM_NIB = 4'h5;
  // link timing in bit times, counted in nibbles
  localparam int JAM_BITS = 32'h30;
  localparam int IFG_BITS = 32'h60;
  localparam int SLOT_BITS = 32'h200;
  localparam logic [7:0] JAM_NIBS = 8'(JAM_BITS / 4);
  localparam logic [7:0] IFG_NIBS = 8'(IFG_BITS / 4);
  localparam logic [7:0] SLOT_NIBS = 8'(SLOT_BITS / 4);
  localparam logic [4:0] RETRY_LIMIT = 5'h10;
  localparam logic [4:0] BACKOFF_CAP = 5'h0A;
  // crc-32, reflected
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;

  typedef enum logic [7:0] {
    TX_IDLE = 8'h01, TX_DEFER = 8'h02, TX_PRE = 8'h04, TX_DATA = 8'h08,
    TX_FCS = 8'h10, TX_JAM = 8'h20, TX_BACKOFF = 8'h40, TX_GAP = 8'h80
  } emc_tx_state_type;
  typedef enum logic [4:0] {
    RX_IDLE = 5'h01, RX_PRE = 5'h02, RX_SFD = 5'h04, RX_DATA = 5'h08, RX_DROP = 5'h10
  } emc_rx_state_type;

  typedef struct packed {
    logic tx_en;
    logic [3:0] txd;
  } emc_mii_tx_type;
  typedef struct packed {
    logic rx_dv;
    logic rx_er;
    logic [3:0] rxd;
    logic crs;
    logic col;
  } emc_mii_rx_type;

  typedef struct packed {
    emc_tx_state_type tx_st;
    emc_rx_state_type rx_st;
    logic [2:0] txc_sy;
    logic [2:0] rxc_sy;
    emc_mii_rx_type rx_s1;
    emc_mii_rx_type rx_s2;
    logic [4:0] ctrl;
    logic [15:0] max_len;
    logic [47:0] mac;
    logic [15:0] tx_wr;
    logic [15:0] tx_pos;
    logic tx_hi;
    logic [7:0] cnt;
    logic [7:0] snib;
    logic [4:0] att;
    logic fail;
    logic [9:0] slots;
    logic [31:0] tx_crc;
    logic [15:0] lfsr;
    logic [15:0] rx_cnt;
    logic [15:0] rx_len;
    logic [15:0] rx_rd;
    logic [3:0] rx_lo;
    logic rx_hi;
    logic rx_bad;
    logic [31:0] rx_crc;
    logic [47:0] rx_da;
    logic [3:0] stat;
    logic [3:0] mask;
    logic irq;
    logic ack;
    logic [31:0] rdat;
    emc_mii_tx_type tx;
  } emc_st_type;
endpackage

// ### src/emc_mac.sv
// emc_mac: frame-level ethernet mac with csma/cd, crc and address filter
// assumes an mii phy whose link clocks are slower than clk_i, and a wishbone master
// Functional notes
// - frames run 64 bytes up to max_rx_frame_length
// - transmit seven 55h preamble bytes; receive syncs on them
// - 5Dh delimiter follows preamble, marks content start
// - drop frames whose destination matches no enabled filter
// - insert own source address after destination
// - two-byte length or type field follows source
// - data field 46 to maximum minus 18 bytes
// - pad short data to 46 before the crc
// - append four-byte crc; check crc on receive
// - crc covers 60 to maximum minus 4 bytes
// - keeping received crc bytes is configurable
// - csma/cd only in half duplex
// - full duplex: no collision, jam or backoff
// - defer while carrier, then wait one gap
// - frame sent without collision counts as done
// - collision aborts frame and sends 48-bit jam
// - random exponential backoff, then retry
`timescale 1ns/100ps
module emc_mac #(
  parameter int MEM_DEPTH = 2048
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  // media independent interface
  input wire logic tx_clk_i,
  input wire logic rx_clk_i,
  input wire emc_pkg::emc_mii_rx_type mii_rx_i,
  output emc_pkg::emc_mii_tx_type mii_tx_o
);
  localparam int AW = $clog2(MEM_DEPTH);

  if (MEM_DEPTH < 64 || MEM_DEPTH > 32768) begin : g_bad_depth
    $error("emc_mac: MEM_DEPTH must lie in 64..32768");
  end

  emc_pkg::emc_st_type s;
  emc_pkg::emc_st_type n;
  logic [7:0] tx_mem [MEM_DEPTH];
  logic [7:0] rx_mem [MEM_DEPTH];
  logic txm_we, rxm_we, te, re, hdx, crs, col, req, go, rd_stat;
  logic [AW-1:0] rxm_wa;
  logic [7:0] rxm_wd, bv, pb;
  logic [3:0] set, nib;
  logic [15:0] tlen, flen;
  logic [31:0] fcs;

  function automatic logic [31:0] crc_nib(input logic [31:0] c, input logic [3:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 4; i++)
    begin
      r = (r >> 1) ^ ((r[0] ^ d[i]) ? emc_pkg::CRC_POLY : 32'h00000000);
    end
    return r;
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] sel);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
        r[i*8 +: 8] = d[i*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic [9:0] bmask(input logic [4:0] a);
    logic [4:0] k;
    k = (a > emc_pkg::BACKOFF_CAP) ? emc_pkg::BACKOFF_CAP : a;
    return 10'((11'h001 << k) - 11'h001);
  endfunction

  // outgoing byte at frame position p, before the check sequence
  function automatic logic [7:0] fbyte(input logic [15:0] p);
    logic [15:0] q;
    q = p - emc_pkg::ADDR_BYTES;
    if (p < emc_pkg::ADDR_BYTES)
      return tx_mem[p[AW-1:0]];
    else if (q < emc_pkg::ADDR_BYTES)
      return 8'(s.mac >> {q[2:0], 3'h0});
    else if (q < s.tx_wr)
      return tx_mem[q[AW-1:0]];
    else
      return 8'h00;
  endfunction

  function automatic logic addr_ok(input logic [47:0] da);
    return (da == s.mac) || (&da && s.ctrl[emc_pkg::CTRL_BCAST])
      || (da[0] && s.ctrl[emc_pkg::CTRL_MCAST]) || s.ctrl[emc_pkg::CTRL_PROM];
  endfunction

  always_comb
  begin
    n = s;
    txm_we = 1'b0;
    rxm_we = 1'b0;
    rxm_wa = '0;
    rxm_wd = 8'h00;
    go = 1'b0;
    rd_stat = 1'b0;
    set = 4'h0;
    bv = 8'h00;
    pb = 8'h00;
    nib = 4'h0;
    fcs = ~s.tx_crc;
    // link clocks are sampled; edges come from the second and third stages
    n.txc_sy = {s.txc_sy[1:0], tx_clk_i};
    n.rxc_sy = {s.rxc_sy[1:0], rx_clk_i};
    n.rx_s1 = mii_rx_i;
    n.rx_s2 = s.rx_s1;
    te = s.txc_sy[1] & ~s.txc_sy[2];
    re = s.rxc_sy[1] & ~s.rxc_sy[2];
    hdx = ~s.ctrl[emc_pkg::CTRL_FDX];
    crs = s.rx_s2.crs;
    col = s.rx_s2.col;
    n.lfsr = {s.lfsr[14:0], s.lfsr[15] ^ s.lfsr[13] ^ s.lfsr[12] ^ s.lfsr[10]};
    tlen = s.tx_wr + emc_pkg::ADDR_BYTES;
    flen = (tlen < emc_pkg::MIN_CRC) ? emc_pkg::MIN_CRC : tlen;
    // bus slave: one wait state, every address answered
    req = wb_cyc_i & wb_stb_i & ~s.ack;
    n.ack = req;
    if (req)
    begin
      n.rdat = 32'h00000000;
      if (wb_we_i)
      begin
        case (wb_adr_i)
          emc_pkg::ADR_CTRL: n.ctrl = 5'(wmerge({27'h0, s.ctrl}, wb_dat_i, wb_sel_i));
          emc_pkg::ADR_MAX_LEN: n.max_len = 16'(wmerge({16'h0, s.max_len}, wb_dat_i, wb_sel_i));
          emc_pkg::ADR_MAC_LO: n.mac[31:0] = wmerge(s.mac[31:0], wb_dat_i, wb_sel_i);
          emc_pkg::ADR_MAC_HI: n.mac[47:32] = 16'(wmerge({16'h0, s.mac[47:32]}, wb_dat_i, wb_sel_i));
          emc_pkg::ADR_TX_DATA:
            if (wb_sel_i[0] && s.tx_st == emc_pkg::TX_IDLE && s.tx_wr < 16'(MEM_DEPTH))
            begin
              txm_we = 1'b1;
              n.tx_wr = s.tx_wr + 16'h0001;
            end
          emc_pkg::ADR_TX_CMD:
            if (wb_sel_i[0] && s.tx_st == emc_pkg::TX_IDLE)
            begin
              go = wb_dat_i[emc_pkg::TXC_GO];
              if (wb_dat_i[emc_pkg::TXC_CLR])
                n.tx_wr = 16'h0000;
            end
          emc_pkg::ADR_INT_MASK: n.mask = 4'(wmerge({28'h0, s.mask}, wb_dat_i, wb_sel_i));
          default: n.ctrl = s.ctrl;
        endcase
      end
      else
      begin
        case (wb_adr_i)
          emc_pkg::ADR_CTRL: n.rdat = {27'h0, s.ctrl};
          emc_pkg::ADR_MAX_LEN: n.rdat = {16'h0, s.max_len};
          emc_pkg::ADR_MAC_LO: n.rdat = s.mac[31:0];
          emc_pkg::ADR_MAC_HI: n.rdat = {16'h0, s.mac[47:32]};
          emc_pkg::ADR_TX_CMD: n.rdat = {10'h0, s.att, s.tx_st != emc_pkg::TX_IDLE, s.tx_wr};
          emc_pkg::ADR_RX_STAT: n.rdat = {16'h0, s.rx_len};
          emc_pkg::ADR_RX_DATA:
          begin
            n.rdat = {24'h0, rx_mem[s.rx_rd[AW-1:0]]};
            n.rx_rd = s.rx_rd + 16'h0001;
          end
          emc_pkg::ADR_INT_STAT:
          begin
            n.rdat = {28'h0, s.stat};
            rd_stat = 1'b1;
          end
          emc_pkg::ADR_INT_MASK: n.rdat = {28'h0, s.mask};
          default: n.rdat = 32'h00000000;
        endcase
      end
    end
    // transmit engine, stepping on tx clock rising edges
    unique case (s.tx_st)
      emc_pkg::TX_IDLE:
        if (go)
        begin
          if (s.tx_wr < emc_pkg::TX_HDR || tlen + emc_pkg::FCS_BYTES > s.max_len)
            set[emc_pkg::IRQ_TX_ERR] = 1'b1;
          else
          begin
            n.att = 5'h00;
            n.cnt = 8'h00;
            n.tx_st = (hdx && crs) ? emc_pkg::TX_DEFER : emc_pkg::TX_PRE;
          end
        end
      emc_pkg::TX_DEFER:
        if (te)
        begin
          if (crs)
            n.cnt = 8'h00;
          else if (s.cnt == emc_pkg::IFG_NIBS - 8'h01)
          begin
            n.cnt = 8'h00;
            n.tx_st = emc_pkg::TX_PRE;
          end
          else
            n.cnt = s.cnt + 8'h01;
        end
      emc_pkg::TX_PRE:
        if (te)
        begin
          pb = (s.cnt < emc_pkg::PRE_NIBS) ? emc_pkg::PRE_BYTE : emc_pkg::SFD_BYTE;
          n.tx.tx_en = 1'b1;
          n.tx.txd = s.cnt[0] ? pb[7:4] : pb[3:0];
          n.cnt = s.cnt + 8'h01;
          if (s.cnt == emc_pkg::PRE_NIBS + 8'h01)
          begin
            n.tx_st = emc_pkg::TX_DATA;
            n.tx_pos = 16'h0000;
            n.tx_hi = 1'b0;
            n.tx_crc = emc_pkg::CRC_INIT;
          end
        end
      emc_pkg::TX_DATA:
        if (te)
        begin
          bv = fbyte(s.tx_pos);
          nib = s.tx_hi ? bv[7:4] : bv[3:0];
          n.tx.txd = nib;
          n.tx_crc = crc_nib(s.tx_crc, nib);
          n.tx_hi = ~s.tx_hi;
          if (s.tx_hi)
          begin
            n.tx_pos = s.tx_pos + 16'h0001;
            if (s.tx_pos + 16'h0001 >= flen)
            begin
              n.cnt = 8'h00;
              n.tx_st = emc_pkg::TX_FCS;
            end
          end
        end
      emc_pkg::TX_FCS:
        if (te)
        begin
          n.tx.txd = 4'(fcs >> {s.cnt[2:0], 2'h0});
          n.cnt = s.cnt + 8'h01;
          if (s.cnt == 8'h07)
          begin
            n.cnt = 8'h00;
            n.fail = 1'b0;
            n.tx_st = emc_pkg::TX_GAP;
          end
        end
      emc_pkg::TX_JAM:
        if (te)
        begin
          n.tx.txd = emc_pkg::JAM_NIB;
          n.cnt = s.cnt + 8'h01;
          if (s.cnt == emc_pkg::JAM_NIBS - 8'h01)
          begin
            n.att = s.att + 5'h01;
            n.cnt = 8'h00;
            if (s.att + 5'h01 >= emc_pkg::RETRY_LIMIT)
            begin
              n.fail = 1'b1;
              n.tx_st = emc_pkg::TX_GAP;
            end
            else
            begin
              n.slots = s.lfsr[9:0] & bmask(s.att + 5'h01);
              n.snib = 8'h00;
              n.tx_st = emc_pkg::TX_BACKOFF;
            end
          end
        end
      emc_pkg::TX_BACKOFF:
        if (te)
        begin
          n.tx.tx_en = 1'b0;
          if (s.slots == 10'h000)
            n.tx_st = emc_pkg::TX_DEFER;
          else if (s.snib == emc_pkg::SLOT_NIBS - 8'h01)
          begin
            n.snib = 8'h00;
            n.slots = s.slots - 10'h001;
          end
          else
            n.snib = s.snib + 8'h01;
        end
      emc_pkg::TX_GAP:
        if (te)
        begin
          n.tx.tx_en = 1'b0;
          n.cnt = s.cnt + 8'h01;
          if (s.cnt == emc_pkg::IFG_NIBS - 8'h01)
          begin
            set[s.fail ? emc_pkg::IRQ_TX_ERR : emc_pkg::IRQ_TX_DONE] = 1'b1;
            n.tx_st = emc_pkg::TX_IDLE;
          end
        end
    endcase
    // collision while on the wire: only in half duplex
    if (te && hdx && col && (s.tx_st == emc_pkg::TX_PRE || s.tx_st == emc_pkg::TX_DATA
        || s.tx_st == emc_pkg::TX_FCS))
    begin
      n.tx.tx_en = 1'b1;
      n.tx.txd = emc_pkg::JAM_NIB;
      n.cnt = 8'h01;
      n.tx_st = emc_pkg::TX_JAM;
    end
    // receive engine, sampling on rx clock rising edges
    unique case (s.rx_st)
      emc_pkg::RX_IDLE:
        if (re && s.rx_s2.rx_dv)
          n.rx_st = emc_pkg::RX_PRE;
      emc_pkg::RX_PRE:
        if (re)
        begin
          if (!s.rx_s2.rx_dv)
            n.rx_st = emc_pkg::RX_IDLE;
          else if (s.rx_s2.rxd == emc_pkg::SFD_BYTE[3:0])
            n.rx_st = emc_pkg::RX_SFD;
        end
      emc_pkg::RX_SFD:
        if (re)
        begin
          n.rx_cnt = 16'h0000;
          n.rx_hi = 1'b0;
          n.rx_bad = 1'b0;
          n.rx_crc = emc_pkg::CRC_INIT;
          if (!s.rx_s2.rx_dv)
            n.rx_st = emc_pkg::RX_IDLE;
          else if (s.rx_s2.rxd == emc_pkg::SFD_BYTE[7:4])
            n.rx_st = emc_pkg::RX_DATA;
          else
            n.rx_st = emc_pkg::RX_PRE;
        end
      emc_pkg::RX_DATA:
        if (re)
        begin
          if (s.rx_s2.rx_dv)
          begin
            n.rx_crc = crc_nib(s.rx_crc, s.rx_s2.rxd);
            n.rx_hi = ~s.rx_hi;
            n.rx_bad = s.rx_bad | s.rx_s2.rx_er;
            if (!s.rx_hi)
              n.rx_lo = s.rx_s2.rxd;
            else
            begin
              bv = {s.rx_s2.rxd, s.rx_lo};
              rxm_we = s.rx_cnt < 16'(MEM_DEPTH);
              rxm_wa = s.rx_cnt[AW-1:0];
              rxm_wd = bv;
              if (s.rx_cnt < emc_pkg::ADDR_BYTES)
                n.rx_da[s.rx_cnt[2:0]*8 +: 8] = bv;
              n.rx_cnt = s.rx_cnt + 16'h0001;
              if (s.rx_cnt == emc_pkg::ADDR_BYTES && !addr_ok(s.rx_da))
                n.rx_st = emc_pkg::RX_DROP;
            end
          end
          else
          begin
            n.rx_st = emc_pkg::RX_IDLE;
            n.rx_rd = 16'h0000;
            n.rx_len = s.ctrl[emc_pkg::CTRL_KEEP_FCS] ? s.rx_cnt
              : s.rx_cnt - emc_pkg::FCS_BYTES;
            if (s.rx_crc == emc_pkg::CRC_RESIDUE && !s.rx_bad && !s.rx_hi
                && s.rx_cnt >= emc_pkg::MIN_FRAME && s.rx_cnt <= s.max_len)
              set[emc_pkg::IRQ_RX_DONE] = 1'b1;
            else
              set[emc_pkg::IRQ_RX_ERR] = 1'b1;
          end
        end
      emc_pkg::RX_DROP:
        if (re && !s.rx_s2.rx_dv)
          n.rx_st = emc_pkg::RX_IDLE;
    endcase
    // a new event wins over the clearing read
    n.stat = (rd_stat ? 4'h0 : s.stat) | set;
    n.irq = |(n.stat & n.mask);
    if (rst_i)
    begin
      n = '0;
      n.tx_st = emc_pkg::TX_IDLE;
      n.rx_st = emc_pkg::RX_IDLE;
      n.max_len = emc_pkg::MAX_LEN_RST;
      n.lfsr = emc_pkg::LFSR_SEED;
      txm_we = 1'b0;
      rxm_we = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    s <= n;
  end

  // frame memories; held apart from the state record
  always_ff @(posedge clk_i)
  begin
    if (txm_we)
      tx_mem[s.tx_wr[AW-1:0]] <= wb_dat_i[7:0];
    if (rxm_we)
      rx_mem[rxm_wa] <= rxm_wd;
  end

  assign wb_dat_o = s.rdat;
  assign wb_ack_o = s.ack;
  assign irq_o = s.irq;
  assign mii_tx_o = s.tx;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence col_hit;
    te && hdx && col && s.tx_st == emc_pkg::TX_DATA;
  endsequence
  sequence jam_last;
    te && s.tx_st == emc_pkg::TX_JAM && s.cnt == emc_pkg::JAM_NIBS - 8'h01;
  endsequence

  chk_ack_single: assert property (s.ack |=> !s.ack)
    else $error("ack held longer than one cycle");
  chk_preamble_nib: assert property (
    (te && s.tx_st == emc_pkg::TX_PRE && s.cnt < emc_pkg::PRE_NIBS && !(hdx && col))
    |=> s.tx.tx_en && s.tx.txd == 4'h5)
    else $error("preamble nibble wrong");
  chk_sfd_nib: assert property (
    (te && s.tx_st == emc_pkg::TX_PRE && s.cnt[7:1] == emc_pkg::PRE_NIBS[7:1] && !(hdx && col))
    |=> s.tx.txd == (s.cnt[0] ? 4'hD : 4'h5))
    else $error("delimiter nibbles wrong");
  chk_col_jam: assert property (col_hit |=> s.tx_st == emc_pkg::TX_JAM && s.tx.txd == emc_pkg::JAM_NIB)
    else $error("collision not answered by jam");
  chk_fdx_no_jam: assert property (
    (te && !hdx && col && s.tx_st == emc_pkg::TX_DATA) |=> s.tx_st != emc_pkg::TX_JAM)
    else $error("jam in full duplex");
  chk_jam_end: assert property (jam_last |=> s.tx_st inside {emc_pkg::TX_BACKOFF, emc_pkg::TX_GAP})
    else $error("jam length wrong");
  chk_defer_hold: assert property ((s.tx_st == emc_pkg::TX_DEFER && crs) |=> s.tx_st == emc_pkg::TX_DEFER)
    else $error("started while carrier present");
  chk_pad_min: assert property (
    ($rose(s.tx_st == emc_pkg::TX_FCS)) |-> s.tx_pos >= emc_pkg::MIN_CRC)
    else $error("frame shorter than minimum before crc");
  chk_rx_drop: assert property (
    (s.rx_st == emc_pkg::RX_DROP) |=> !$rose(s.stat[emc_pkg::IRQ_RX_DONE]))
    else $error("dropped frame reported as received");
  chk_irq_level: assert property (s.irq == |(s.stat & s.mask))
    else $error("interrupt level mismatch");
endmodule

// ### tb/emc_phy_model.sv
// emc_phy_model: mii phy stand-in with free-running link clocks
// assumes the bench drives crs_on/col_on and calls send
`timescale 1ns/100ps
module emc_phy_model (
  // link clocks
  output logic tx_clk_o,
  output logic rx_clk_o,
  // media independent interface
  output emc_pkg::emc_mii_rx_type rx_o,
  input wire emc_pkg::emc_mii_tx_type tx_i
);
  logic [3:0] got[$];
  logic crs_on = 1'b0;
  logic col_on = 1'b0;
  logic er = 1'b0;
  logic dv = 1'b0;
  logic [3:0] d = 4'h0;
  initial
  begin
    tx_clk_o = 1'b0;
    forever #40 tx_clk_o = ~tx_clk_o;
  end
  // receive clock phase unrelated to transmit clock
  initial
  begin
    rx_clk_o = 1'b0;
    #17;
    forever #40 rx_clk_o = ~rx_clk_o;
  end
  always @(posedge tx_clk_o)
    if (tx_i.tx_en === 1'b1)
      got.push_back(tx_i.txd);
  assign rx_o = {dv, er, d, crs_on | dv, col_on};
  task automatic nib(input logic [3:0] v);
    @(negedge rx_clk_o);
    dv = 1'b1;
    d = v;
  endtask
  // preamble, delimiter, then bytes low nibble first
  task automatic send(input logic [7:0] b[$]);
    repeat (14) nib(4'h5);
    nib(4'hD);
    nib(4'h5);
    foreach (b[i])
    begin
      nib(b[i][3:0]);
      nib(b[i][7:4]);
    end
    @(negedge rx_clk_o);
    dv = 1'b0;
    d = ~d;
  endtask
endmodule

// ### tb/tb_top.sv
// tb_top: wishbone-driven bench for the frame-level mac
// assumes the phy model for link clocks, capture and receive traffic
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, tx_clk_i, rx_clk_i, wb_ack_o, irq_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [3:0] sel = 4'hF;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  emc_pkg::emc_mii_rx_type mii_rx_i;
  emc_pkg::emc_mii_tx_type mii_tx_o;
  int miscompares = 0;
  int checks = 0;
  int n, p, q;
  logic [7:0] f[$];
  logic [7:0] x[$];
  logic [3:0] nb[$];
  logic [47:0] own = 48'h9A7856341202;
  logic [47:0] dst[6] = '{48'h9A7856341202, 48'h9A7856341204, 48'h9A7856341204, 48'hFFFFFFFFFFFF,
    48'hFFFFFFFFFFFF, 48'hFFFFFFFFFFFF};
  logic [7:0] ctl[6] = '{8'h11, 8'h11, 8'h13, 8'h11, 8'h19, 8'h15};
  logic [31:0] ev[6] = '{32'h4, 32'h0, 32'h4, 32'h0, 32'h4, 32'h4};
  emc_mac #(.MEM_DEPTH(2048)) emc_mac_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .tx_clk_i, .rx_clk_i, .mii_rx_i, .mii_tx_o);
  emc_phy_model emc_phy_model_inst (.tx_clk_o(tx_clk_i), .rx_clk_o(rx_clk_i), .rx_o(mii_rx_i),
    .tx_i(mii_tx_o));
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // one classic cycle; entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_sel_i <= sel;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1)
      @(posedge clk_i);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask
  task automatic wait_irq(input int lim);
    int k;
    k = 0;
    do begin @(posedge clk_i); k++; end while (irq_o !== 1'b1 && k < lim);
  endtask
  // frame content with own source, short payload padded to 46, then fcs
  task automatic mkf(input logic [47:0] a);
    logic [31:0] c;
    f = {};
    for (int i = 0; i < 6; i++) f.push_back(a[8 * i +: 8]);
    for (int i = 0; i < 6; i++) f.push_back(own[8 * i +: 8]);
    f.push_back(8'h00);
    f.push_back(8'h2E);
    while (f.size() < 60) f.push_back(8'h00);
    c = emc_pkg::CRC_INIT;
    foreach (f[i])
    begin
      c ^= {24'h0, f[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ emc_pkg::CRC_POLY : c >> 1;
    end
    for (int i = 0; i < 4; i++) f.push_back(~c[8 * i +: 8]);
  endtask
  // load destination and length bytes of f, then start
  task automatic txgo(input int k);
    bus(1'b1, emc_pkg::ADR_TX_CMD, 32'h2);
    for (int i = 0; i < k; i++) bus(1'b1, emc_pkg::ADR_TX_DATA, {24'h0, f[i < 6 ? i : i + 6]});
    emc_phy_model_inst.got.delete();
    bus(1'b1, emc_pkg::ADR_TX_CMD, 32'h1);
  endtask
  initial
  begin
    #600000;
    miscompares++;
    give_verdict();
  end
  initial
  begin
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_sel_i = 4'h0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk_rd(emc_pkg::ADR_CTRL, 32'h0, "ctrl");
    chk_rd(emc_pkg::ADR_MAX_LEN, 32'h5EE, "max len");
    chk_rd(emc_pkg::ADR_INT_MASK, 32'h0, "mask");
    chk_rd(8'h3C, 32'h0, "unmapped");
    bus(1'b1, emc_pkg::ADR_MAC_LO, own[31:0]);
    bus(1'b1, emc_pkg::ADR_MAC_HI, {16'h0, own[47:32]});
    bus(1'b1, emc_pkg::ADR_INT_MASK, 32'hF);
    sel = 4'h0;
    bus(1'b1, emc_pkg::ADR_CTRL, 32'h1F);
    sel = 4'hF;
    chk_rd(emc_pkg::ADR_CTRL, 32'h0, "no lanes");
    bus(1'b1, emc_pkg::ADR_CTRL, 32'h1);
    $display("test registers done");
    // full duplex with busy carrier and collision lines
    emc_phy_model_inst.crs_on <= 1'b1;
    emc_phy_model_inst.col_on <= 1'b1;
    mkf(own);
    txgo(8);
    wait_irq(5000);
    chk_rd(emc_pkg::ADR_INT_STAT, 32'h1, "tx done");
    `CHK("irq clear", 1'b0, irq_o)
    bus(1'b0, emc_pkg::ADR_TX_CMD, 32'h0);
    `CHK("collisions", 5'h0, rd[21:17])
    nb = emc_phy_model_inst.got;
    x = f;
    x.push_front(8'h5D);
    repeat (7) x.push_front(8'h55);
    `CHK("nibbles", 144, nb.size())
    if (nb.size() == 144)
      for (int i = 0; i < 72; i++)
        `CHK("tx byte", x[i], {nb[2 * i + 1], nb[2 * i]})
    emc_phy_model_inst.crs_on <= 1'b0;
    emc_phy_model_inst.col_on <= 1'b0;
    $display("test transmit done");
    emc_phy_model_inst.send(f);
    wait_irq(300);
    chk_rd(emc_pkg::ADR_INT_STAT, 32'h4, "rx good");
    chk_rd(emc_pkg::ADR_RX_STAT, 32'h3C, "rx length");
    chk_rd(emc_pkg::ADR_RX_DATA, {24'h0, f[0]}, "rx byte");
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b1, emc_pkg::ADR_CTRL, {24'h0, ctl[i]});
      mkf(dst[i]);
      emc_phy_model_inst.send(f);
      wait_irq(300);
      chk_rd(emc_pkg::ADR_INT_STAT, ev[i], "filter");
    end
    chk_rd(emc_pkg::ADR_RX_STAT, 32'h40, "rx length fcs");
    for (int k = 0; k < 2; k++)
    begin
      bus(1'b1, emc_pkg::ADR_MAX_LEN, 32'h40 - k);
      emc_phy_model_inst.send(f);
      wait_irq(300);
      chk_rd(emc_pkg::ADR_INT_STAT, k ? 32'h8 : 32'h4, "max length");
    end
    bus(1'b1, emc_pkg::ADR_MAX_LEN, 32'h5EE);
    f[63] = ~f[63];
    emc_phy_model_inst.send(f);
    wait_irq(300);
    chk_rd(emc_pkg::ADR_INT_STAT, 32'h8, "rx crc");
    f[63] = ~f[63];
    emc_phy_model_inst.er <= 1'b1;
    emc_phy_model_inst.send(f);
    emc_phy_model_inst.er <= 1'b0;
    wait_irq(300);
    chk_rd(emc_pkg::ADR_INT_STAT, 32'h8, "rx symbol error");
    $display("test receive done");
    txgo(2);
    wait_irq(300);
    chk_rd(emc_pkg::ADR_INT_STAT, 32'h2, "tx short");
    `CHK("short sent", 0, emc_phy_model_inst.got.size())
    // half duplex: defer while carrier, then one gap
    mkf(own);
    bus(1'b1, emc_pkg::ADR_CTRL, 32'h0);
    emc_phy_model_inst.crs_on <= 1'b1;
    txgo(8);
    repeat (300) @(posedge clk_i);
    `CHK("deferred", 1'b0, mii_tx_o.tx_en)
    emc_phy_model_inst.crs_on <= 1'b0;
    n = 0;
    while (mii_tx_o.tx_en !== 1'b1 && n < 1000) begin @(posedge clk_i); n++; end
    `CHK("gap", 1'b1, n >= 230 && n < 300)
    wait_irq(5000);
    chk_rd(emc_pkg::ADR_INT_STAT, 32'h1, "defer done");
    $display("test defer done");
    txgo(8);
    n = 0;
    while (mii_tx_o.tx_en !== 1'b1 && n < 2000) begin @(posedge clk_i); n++; end
    repeat (400) @(posedge clk_i);
    p = emc_phy_model_inst.got.size();
    emc_phy_model_inst.crs_on <= 1'b1;
    emc_phy_model_inst.col_on <= 1'b1;
    repeat (200) @(posedge clk_i);
    q = emc_phy_model_inst.got.size();
    emc_phy_model_inst.crs_on <= 1'b0;
    emc_phy_model_inst.col_on <= 1'b0;
    `CHK("jam", 1'b1, q - p >= 12 && q - p <= 15)
    wait_irq(20000);
    chk_rd(emc_pkg::ADR_INT_STAT, 32'h1, "retry done");
    `CHK("retry frame", q + 144, emc_phy_model_inst.got.size())
    bus(1'b0, emc_pkg::ADR_TX_CMD, 32'h0);
    `CHK("collision count", 5'h1, rd[21:17])
    $display("test collision done");
    give_verdict();
  end
endmodule
